// ---- shared/lamp_pkg.sv ----
// Constants and types for the I/O block status lamp logic
package lamp_pkg;
    localparam int NUM_CH = 4;
    localparam int TICK_W = 24;
    // Lamp timebase: one step of the pattern every 50 ms at 40 MHz
    localparam int CLK_HZ = 40_000_000;
    localparam int STEP_MS = 50;
    localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    localparam logic [TICK_W-1:0] STEP_DEF = TICK_W'(STEP_CYC);
    // Pattern frame: 16 steps; flash 4 on/4 off, single = one pulse
    localparam int PH_W = 4;
    localparam logic [15:0] PAT_FLASH  = 16'hF0F0;
    localparam logic [15:0] PAT_SINGLE = 16'h0007;
    localparam logic [15:0] PAT_DOUBLE = 16'h0077;

    typedef enum logic [1:0] {
        BUS_NOPWR,
        BUS_PREOP,
        BUS_OPER,
        BUS_ERR
    } bus_state_t;

    typedef enum logic [1:0] {
        BLK_NOPWR,
        BLK_RESET,
        BLK_PREOP,
        BLK_OPER
    } blk_state_t;
endpackage : lamp_pkg

// ---- tb/lamp_observer.sv ----
// Operator model that counts the lit cycles of every lamp
`timescale 1ns/1ps
module lamp_observer (
    // Clock and observation window
    input  wire logic       clk,
    input  wire logic       window,
    // Lamps, high = lit
    input  wire logic [7:0] lamps,
    // Lit-cycle count per lamp
    output logic      [7:0] lit_cnt [8]
);
    // A whole frame is counted, so the result does not depend on phase
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!window) begin
                lit_cnt[i] <= 8'h00;
            end else begin
                lit_cnt[i] <= lit_cnt[i] + {7'h00, lamps[i]};
            end
        end
    end
endmodule : lamp_observer

// ---- tb/tb_io_block_status_indicator.sv ----
// Self-checking bench for the status lamp driver
`timescale 1ns/1ps
module tb_io_block_status_indicator;
    import lamp_pkg::*;
    // Lit cycles in one 16-step frame of 2 cycles per step
    localparam logic [7:0] F = 8'h20, H = 8'h10, S = 8'h06, D = 8'h0C;
    localparam logic [7:0] Z = 8'h00;
    // Same frame at 3 cycles per step
    localparam logic [7:0] F3 = 8'h30, H3 = 8'h18, S3 = 8'h09, D3 = 8'h12;
    logic              sys_clk = 1'h0, srst = 1'h1, window = 1'h0;
    logic [TICK_W-1:0] step_cycles = 24'h000002;
    logic              bus_power = 1'h0, bus_operational = 1'h0;
    logic              bus_error = 1'h0, blk_supply = 1'h0;
    logic              blk_in_reset = 1'h0, blk_operational = 1'h0;
    logic              blk_error = 1'h0, supply_bad = 1'h0;
    logic [NUM_CH-1:0] ch_unused = 4'h0, ch_open = 4'h0, ch_valid = 4'h0;
    logic [NUM_CH-1:0] ch_range_err = 4'h0, ch_interrupted = 4'h0;
    logic              bus_green, bus_red, blk_green, blk_red;
    logic [NUM_CH-1:0] ch_green;
    logic [7:0]        lit_cnt [8];
    int                err_count = 0, n_tests = 0;

    io_block_status_indicator u_dut (.sys_clk, .srst, .step_cycles,
        .bus_power, .bus_operational, .bus_error, .ch_unused, .ch_open,
        .ch_range_err, .ch_interrupted, .ch_valid, .blk_supply,
        .blk_in_reset, .blk_operational, .blk_error, .supply_bad,
        .bus_green, .bus_red, .ch_green, .blk_green, .blk_red);
    lamp_observer u_obs (.clk(sys_clk), .window,
        .lamps({blk_red, blk_green, ch_green, bus_red, bus_green}),
        .lit_cnt);

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t lamp count %0d expected %0d",
                     $time, seen, exp);
        end
    endtask : check

    // Expected: {blk_r, blk_g, ch4, ch3, ch2, ch1, bus_r, bus_g}
    // The closing edge wait lets callers change inputs on a rising edge
    task automatic measure(input logic [63:0] e, input int cyc = 32);
        repeat (3) @(posedge sys_clk);
        window <= 1'h1;
        repeat (cyc) @(posedge sys_clk);
        window <= 1'h0;
        #1;
        for (int i = 0; i < 8; i++) begin
            check(lit_cnt[i], e[8*i +: 8]);
        end
        @(posedge sys_clk);
    endtask : measure

    task automatic t_bus;
        @(posedge sys_clk);
        bus_power <= 1'h1;
        ch_unused <= 4'h8;
        measure({48'h0, F, F});
        bus_operational <= 1'h1;
        measure({48'h0, Z, F});
        bus_error <= 1'h1;
        measure({48'h0, F, Z});
        bus_power <= 1'h0;
        measure(64'h0);
        $display("bus lamp test done");
    endtask : t_bus

    task automatic t_chan;
        blk_supply <= 1'h1;
        blk_operational <= 1'h1;
        ch_unused <= 4'h1;
        ch_open <= 4'h2;
        ch_range_err <= 4'h7;
        ch_valid <= 4'hF;
        measure({S, F, F, H, Z, Z, Z, Z});
        ch_range_err <= 4'h0;
        ch_interrupted <= 4'h8;
        ch_valid <= 4'h4;
        measure({S, F, H, F, Z, Z, Z, Z});
        ch_interrupted <= 4'h0;
        measure({Z, F, Z, F, Z, Z, Z, Z});
        $display("channel lamp test done");
    endtask : t_chan

    task automatic t_blk;
        blk_operational <= 1'h0;
        measure({Z, H, Z, F, Z, Z, Z, Z});
        blk_in_reset <= 1'h1;
        measure({F, S, Z, F, Z, Z, Z, Z});
        blk_in_reset <= 1'h0;
        supply_bad <= 1'h1;
        ch_interrupted <= 4'h8;
        measure({D, H, H, F, Z, Z, Z, Z});
        blk_error <= 1'h1;
        measure({F, H, H, F, Z, Z, Z, Z});
        blk_supply <= 1'h0;
        measure({Z, Z, H, F, Z, Z, Z, Z});
        $display("block lamp test done");
    endtask : t_blk

    task automatic t_step;
        step_cycles <= 24'h000003;
        blk_supply <= 1'h1;
        blk_error <= 1'h0;
        supply_bad <= 1'h0;
        ch_unused <= 4'h0;
        ch_open <= 4'h0;
        ch_valid <= 4'hF;
        ch_range_err <= 4'h2;
        measure({S3, H3, H3, F3, H3, F3, Z, Z}, 48);
        ch_range_err <= 4'h1;
        ch_open <= 4'h4;
        supply_bad <= 1'h1;
        measure({D3, H3, H3, Z, F3, H3, Z, Z}, 48);
        $display("timebase step test done");
    endtask : t_step

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Watchdog: the tests need about 600 cycles
    initial begin
        #(25 * 4000);
        err_count++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'h0;
        t_bus();
        t_chan();
        t_blk();
        t_step();
        final_report();
    end
endmodule : tb_io_block_status_indicator

// ---- verilog/io_block_status_indicator.sv ----
// Status lamp driver for a four-channel analog input block
`timescale 1ns/1ps
// Notes on behaviour
// - Both bus lamps dark without bus power.
// - Both bus lamps lit steadily while bus preoperational.
// - Only green bus lamp lit while bus operational.
// - Only red bus lamp lit on detected bus error.
// - Four green channel lamps, each from its own channel.
// - Channel lamp dark when open, disconnected or unused.
// - Channel lamp flashes on overflow, underflow or interrupted link.
// - Channel lamp steady when converter runs with valid value.
// - Green block lamp: dark, single flash, flashing, steady per state.
// - Red block lamp dark when no fault or no supply.
// - Red block lamp single-flashes on any error of a channel not marked unused.
// - Red block lamp double-flashes when supply out of range.
// - Red block lamp steady on block error or in reset.
module io_block_status_indicator (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    // Timebase step length in clock cycles
    input  wire logic [lamp_pkg::TICK_W-1:0] step_cycles,
    // Expansion bus state
    input  wire logic                        bus_power,
    input  wire logic                        bus_operational,
    input  wire logic                        bus_error,
    // Per-channel converter state
    input  wire logic [lamp_pkg::NUM_CH-1:0] ch_unused,
    input  wire logic [lamp_pkg::NUM_CH-1:0] ch_open,
    input  wire logic [lamp_pkg::NUM_CH-1:0] ch_range_err,
    input  wire logic [lamp_pkg::NUM_CH-1:0] ch_interrupted,
    input  wire logic [lamp_pkg::NUM_CH-1:0] ch_valid,
    // Block state and supervision
    input  wire logic                        blk_supply,
    input  wire logic                        blk_in_reset,
    input  wire logic                        blk_operational,
    input  wire logic                        blk_error,
    input  wire logic                        supply_bad,
    // Lamps, high = lit
    output logic                             bus_green,
    output logic                             bus_red,
    output logic [lamp_pkg::NUM_CH-1:0]      ch_green,
    output logic                             blk_green,
    output logic                             blk_red
);
    import lamp_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [TICK_W-1:0] tick;
        logic [PH_W-1:0]   phase;
        logic              bus_g;
        logic              bus_r;
        logic [NUM_CH-1:0] ch_g;
        logic              blk_g;
        logic              blk_r;
    } state_t;

    state_t st_reg;
    state_t st_next;

    function automatic logic pat_bit(input logic [15:0] pat,
                                     input logic [PH_W-1:0] ph);
        pat_bit = pat[ph];
    endfunction : pat_bit

    bus_state_t bus_st;
    blk_state_t blk_st;
    logic flash;
    logic single;
    logic dbl;
    logic any_ch_err;
    logic [NUM_CH-1:0] ch_bad;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_next = st_reg;
        // Zero step is treated as one so the timebase never stalls
        if (st_reg.tick + TICK_W'(1) >= step_cycles) begin
            st_next.tick  = '0;
            st_next.phase = st_reg.phase + PH_W'(1);
        end else begin
            st_next.tick = st_reg.tick + TICK_W'(1);
        end
        flash  = pat_bit(PAT_FLASH, st_reg.phase);
        single = pat_bit(PAT_SINGLE, st_reg.phase);
        dbl    = pat_bit(PAT_DOUBLE, st_reg.phase);

        // Error beats operational so a faulted bus never shows green only
        if (!bus_power)
            bus_st = BUS_NOPWR;
        else if (bus_error)
            bus_st = BUS_ERR;
        else if (bus_operational)
            bus_st = BUS_OPER;
        else
            bus_st = BUS_PREOP;
        case (bus_st)
            BUS_NOPWR: begin
                st_next.bus_g = 1'h0;
                st_next.bus_r = 1'h0;
            end
            BUS_PREOP: begin
                st_next.bus_g = 1'h1;
                st_next.bus_r = 1'h1;
            end
            BUS_OPER: begin
                st_next.bus_g = 1'h1;
                st_next.bus_r = 1'h0;
            end
            BUS_ERR: begin
                st_next.bus_g = 1'h0;
                st_next.bus_r = 1'h1;
            end
            default: begin
                st_next.bus_g = 1'h0;
                st_next.bus_r = 1'h0;
            end
        endcase

        ch_bad = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            ch_bad[i] = ch_range_err[i] | ch_interrupted[i];
            if (ch_unused[i] || ch_open[i])
                st_next.ch_g[i] = 1'h0;
            else if (ch_bad[i])
                st_next.ch_g[i] = flash;
            else
                st_next.ch_g[i] = ch_valid[i];
        end
        // Unused channels never raise a block-level channel error
        any_ch_err = |(ch_bad & ~ch_unused);

        if (!blk_supply)
            blk_st = BLK_NOPWR;
        else if (blk_in_reset)
            blk_st = BLK_RESET;
        else if (blk_operational)
            blk_st = BLK_OPER;
        else
            blk_st = BLK_PREOP;
        case (blk_st)
            BLK_NOPWR: st_next.blk_g = 1'h0;
            BLK_RESET: st_next.blk_g = single;
            BLK_PREOP: st_next.blk_g = flash;
            BLK_OPER:  st_next.blk_g = 1'h1;
            default:   st_next.blk_g = 1'h0;
        endcase

        if (!blk_supply)
            st_next.blk_r = 1'h0;
        else if (blk_error || blk_in_reset)
            st_next.blk_r = 1'h1;
        else if (supply_bad)
            st_next.blk_r = dbl;
        else if (any_ch_err)
            st_next.blk_r = single;
        else
            st_next.blk_r = 1'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign bus_green = st_reg.bus_g;
    assign bus_red   = st_reg.bus_r;
    assign ch_green  = st_reg.ch_g;
    assign blk_green = st_reg.blk_g;
    assign blk_red   = st_reg.blk_r;

    // ********************************************************
    // Checks
    // ********************************************************
    a_bus_dark: assert property (
        @(posedge sys_clk) disable iff (srst)
        !bus_power |=> !bus_green && !bus_red)
        else $error("bus lamps lit without bus power");
    a_bus_preop: assert property (
        @(posedge sys_clk) disable iff (srst)
        bus_power && !bus_error && !bus_operational
        |=> bus_green && bus_red)
        else $error("bus preop lamps wrong");
    a_bus_oper: assert property (
        @(posedge sys_clk) disable iff (srst)
        bus_power && !bus_error && bus_operational
        |=> bus_green && !bus_red)
        else $error("bus operational lamps wrong");
    a_bus_err: assert property (
        @(posedge sys_clk) disable iff (srst)
        bus_power && bus_error |=> !bus_green && bus_red)
        else $error("bus error lamps wrong");
    a_ch_dark: assert property (
        @(posedge sys_clk) disable iff (srst)
        (ch_unused[0] || ch_open[0]) |=> !ch_green[0])
        else $error("channel lamp lit while open");
    a_ch2_dark: assert property (
        @(posedge sys_clk) disable iff (srst)
        (ch_unused[1] || ch_open[1]) |=> !ch_green[1])
        else $error("channel 2 lamp lit while open");
    a_ch3_dark: assert property (
        @(posedge sys_clk) disable iff (srst)
        (ch_unused[2] || ch_open[2]) |=> !ch_green[2])
        else $error("channel 3 lamp lit while open");
    a_ch4_dark: assert property (
        @(posedge sys_clk) disable iff (srst)
        (ch_unused[3] || ch_open[3]) |=> !ch_green[3])
        else $error("channel 4 lamp lit while open");
    a_ch_steady: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[0] && !ch_open[0] && !ch_range_err[0]
        && !ch_interrupted[0] && ch_valid[0] |=> ch_green[0])
        else $error("channel lamp not steady");
    a_ch2_steady: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[1] && !ch_open[1] && !ch_range_err[1]
        && !ch_interrupted[1] && ch_valid[1] |=> ch_green[1])
        else $error("channel 2 lamp not steady");
    a_ch3_steady: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[2] && !ch_open[2] && !ch_range_err[2]
        && !ch_interrupted[2] && ch_valid[2] |=> ch_green[2])
        else $error("channel 3 lamp not steady");
    a_ch4_steady: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[3] && !ch_open[3] && !ch_range_err[3]
        && !ch_interrupted[3] && ch_valid[3] |=> ch_green[3])
        else $error("channel 4 lamp not steady");
    a_ch_flash: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[0] && !ch_open[0]
        && (ch_range_err[0] || ch_interrupted[0])
        |=> ch_green[0] == PAT_FLASH[$past(st_reg.phase)])
        else $error("channel lamp not flashing");
    a_ch2_flash: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[1] && !ch_open[1]
        && (ch_range_err[1] || ch_interrupted[1])
        |=> ch_green[1] == PAT_FLASH[$past(st_reg.phase)])
        else $error("channel 2 lamp not flashing");
    a_ch3_flash: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[2] && !ch_open[2]
        && (ch_range_err[2] || ch_interrupted[2])
        |=> ch_green[2] == PAT_FLASH[$past(st_reg.phase)])
        else $error("channel 3 lamp not flashing");
    a_ch4_flash: assert property (
        @(posedge sys_clk) disable iff (srst)
        !ch_unused[3] && !ch_open[3]
        && (ch_range_err[3] || ch_interrupted[3])
        |=> ch_green[3] == PAT_FLASH[$past(st_reg.phase)])
        else $error("channel 4 lamp not flashing");
    a_blk_oper: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && !blk_in_reset && blk_operational |=> blk_green)
        else $error("block green not steady");
    a_blk_single: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && blk_in_reset
        |=> blk_green == PAT_SINGLE[$past(st_reg.phase)])
        else $error("block green not single flash in reset");
    a_blk_preop: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && !blk_in_reset && !blk_operational
        |=> blk_green == PAT_FLASH[$past(st_reg.phase)])
        else $error("block green not flashing");
    a_red_reset: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && blk_in_reset |=> blk_red)
        else $error("block red not steady in reset");
    a_red_error: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && blk_error |=> blk_red)
        else $error("block red not steady on block error");
    a_red_double: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && !blk_error && !blk_in_reset && supply_bad
        |=> blk_red == PAT_DOUBLE[$past(st_reg.phase)])
        else $error("block red not double flash");
    a_red_single: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && !blk_error && !blk_in_reset && !supply_bad
        && |((ch_range_err | ch_interrupted) & ~ch_unused)
        |=> blk_red == PAT_SINGLE[$past(st_reg.phase)])
        else $error("block red not single flash");
    a_red_ok: assert property (
        @(posedge sys_clk) disable iff (srst)
        blk_supply && !blk_error && !blk_in_reset && !supply_bad
        && !(|((ch_range_err | ch_interrupted) & ~ch_unused))
        |=> !blk_red)
        else $error("block red lit without fault");
    a_red_nosup: assert property (
        @(posedge sys_clk) disable iff (srst)
        !blk_supply |=> !blk_red && !blk_green)
        else $error("block lamps lit without supply");
    a_phase_step: assert property (
        @(posedge sys_clk) disable iff (srst)
        $changed(st_reg.phase)
        |-> st_reg.phase == $past(st_reg.phase) + 4'h1)
        else $error("timebase phase skipped");
    a_tick_bound: assert property (
        @(posedge sys_clk) disable iff (srst)
        step_cycles != '0 && $stable(step_cycles)
        |-> st_reg.tick < step_cycles)
        else $error("timebase tick passed its step length");
endmodule : io_block_status_indicator
